//--- assi_pkg.sv
// Purpose: Constants for the sequence input-select register block.
// Assumes: 32-bit register port, one register word.
// Notes: Offsets are byte addresses on the plain register port.
package assi_pkg;
  // Register offset of the select register.
  localparam logic [7:0] SEL_OFFSET = 8'h40;
  // Reset value of the select register.
  localparam logic [31:0] SEL_RESET = 32'h0000_0000;
  // Mask of the writable bits; all gaps read as zero.
  localparam logic [31:0] SEL_WMASK = 32'h3333_3333;
  // Spacing in bits between two step fields, and the field width.
  localparam int FIELD_STRIDE = 4;
  localparam int FIELD_WIDTH = 2;
  // Number of steps in one sequence.
  localparam int STEP_COUNT = 8;
endpackage

//--- assi_select.sv
// Purpose: Input-select register of one sample sequencer.
// Assumes: Sequencer gives the current step index and a step-active level.
// Notes: The channel code goes straight to the analog multiplexer.
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/100ps

module assi_select (
  // Clock and reset.
  input wire logic CLK_I,
  input wire logic RST_B_I,
  // Register port.
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  // Sequencer side.
  input wire logic [2:0] STEP_I,
  input wire logic STEP_ACTIVE_I,
  output logic [1:0] CHANNEL_O
);

  logic [31:0] sel_ff;
  logic [31:0] nxt_sel;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [1:0] chan_ff;
  logic [1:0] nxt_chan;
  logic active_q_ff;
  logic nxt_active;
  // Named copies of the eight step fields, for the per-step checks.
  logic [1:0] step1_channel;
  logic [1:0] step2_channel;
  logic [1:0] step3_channel;
  logic [1:0] step4_channel;
  logic [1:0] step5_channel;
  logic [1:0] step6_channel;
  logic [1:0] step7_channel;
  logic [1:0] step8_channel;

  // Field of a given step; used by the live mux and the assertions.
  function automatic logic [1:0] field_of(input logic [31:0] r, input logic [2:0] s);
    field_of = r[s * assi_pkg::FIELD_STRIDE +: assi_pkg::FIELD_WIDTH];
  endfunction

  // Address match of the select register; shared by the write and read paths.
  function automatic logic sel_hit(input logic [7:0] a);
    sel_hit = (a == assi_pkg::SEL_OFFSET);
  endfunction

  // Per-step fields split out of the register word.
  // They cost no gates; the names only keep the per-step checks readable.
  // step one field
  assign step1_channel = field_of(sel_ff, 3'h0);
  assign step2_channel = field_of(sel_ff, 3'h1);
  assign step3_channel = field_of(sel_ff, 3'h2);
  assign step4_channel = field_of(sel_ff, 3'h3);
  assign step5_channel = field_of(sel_ff, 3'h4);
  assign step6_channel = field_of(sel_ff, 3'h5);
  assign step7_channel = field_of(sel_ff, 3'h6);
  assign step8_channel = field_of(sel_ff, 3'h7);

  // Register writes keep only the field bits.
  // gaps forced zero
  always_comb begin
    nxt_sel = sel_ff;
    if (WR_I && sel_hit(ADDR_I)) begin
      nxt_sel = WDATA_I & assi_pkg::SEL_WMASK;
    end
  end

  // Read data stands only in the cycle after the strobe; unmapped reads give zero.
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (RD_I && sel_hit(ADDR_I)) begin
      nxt_rdata = sel_ff;
    end
  end

  // latch at step start so a mid-step write cannot disturb the conversion.
  // A limitation: back-to-back steps need the active level to drop for one cycle.
  always_comb begin
    nxt_chan = chan_ff;
    if (STEP_ACTIVE_I && !active_q_ff) begin
      nxt_chan = field_of(sel_ff, STEP_I);
    end else if (!STEP_ACTIVE_I) begin
      nxt_chan = field_of(sel_ff, STEP_I);
    end
  end

  // Step-active history, used to spot the start of a step.
  always_comb begin
    nxt_active = STEP_ACTIVE_I;
  end

  // Select register; reset clears every field.
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      sel_ff <= assi_pkg::SEL_RESET;
    end else begin
      sel_ff <= nxt_sel;
    end
  end

  // Read data register; zero outside the read slot.
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Channel output and step history; reset drives channel zero.
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      chan_ff <= 2'h0;
      active_q_ff <= 1'b0;
    end else begin
      chan_ff <= nxt_chan;
      active_q_ff <= nxt_active;
    end
  end

  assign RDATA_O = rdata_ff;
  assign CHANNEL_O = chan_ff;

  // Checks on the register word and the read port.
  // gaps stay zero
  gaps_zero_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (sel_ff & ~assi_pkg::SEL_WMASK) == 32'h0000_0000)
    else $error("Reserved select bits not zero");

  write_store_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (WR_I && sel_hit(ADDR_I)) |=> sel_ff == ($past(WDATA_I) & assi_pkg::SEL_WMASK))
    else $error("Write not stored");

  read_data_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (RD_I && sel_hit(ADDR_I)) |=> RDATA_O == $past(sel_ff))
    else $error("Read data wrong");

  unmapped_zero_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (RD_I && !sel_hit(ADDR_I)) |=> RDATA_O == 32'h0000_0000)
    else $error("Unmapped read not zero");

  no_read_zero_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (!RD_I) |=> RDATA_O == 32'h0000_0000)
    else $error("Read data outside read slot");

  write_ignored_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (WR_I && !sel_hit(ADDR_I)) |=> $stable(sel_ff))
    else $error("Unmapped write changed the register");

  read_gaps_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (RD_I && sel_hit(ADDR_I)) |=> (RDATA_O & ~assi_pkg::SEL_WMASK) == 32'h0000_0000)
    else $error("Reserved bits read as one");

  write_read_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (WR_I && sel_hit(ADDR_I)) ##1 (RD_I && sel_hit(ADDR_I))
    |=> RDATA_O == ($past(WDATA_I, 2) & assi_pkg::SEL_WMASK))
    else $error("Read after write wrong");

  // Checks of the reset values.
  // reset clears fields
  reset_clear_a: assert property (@(posedge CLK_I)
    $rose(RST_B_I) |-> sel_ff == assi_pkg::SEL_RESET)
    else $error("Select fields not cleared by reset");

  reset_step2_a: assert property (@(posedge CLK_I)
    $rose(RST_B_I) |-> step2_channel == 2'h0)
    else $error("Step two field not cleared by reset");

  reset_step3_a: assert property (@(posedge CLK_I)
    $rose(RST_B_I) |-> step3_channel == 2'h0)
    else $error("Step three field not cleared by reset");

  reset_step4_a: assert property (@(posedge CLK_I)
    $rose(RST_B_I) |-> step4_channel == 2'h0)
    else $error("Step four field not cleared by reset");

  reset_step5_a: assert property (@(posedge CLK_I)
    $rose(RST_B_I) |-> step5_channel == 2'h0)
    else $error("Step five field not cleared by reset");

  reset_step6_a: assert property (@(posedge CLK_I)
    $rose(RST_B_I) |-> step6_channel == 2'h0)
    else $error("Step six field not cleared by reset");

  reset_step7_a: assert property (@(posedge CLK_I)
    $rose(RST_B_I) |-> step7_channel == 2'h0)
    else $error("Step seven field not cleared by reset");

  chan_reset_a: assert property (@(posedge CLK_I)
    $rose(RST_B_I) |-> CHANNEL_O == 2'h0 && RDATA_O == 32'h0000_0000)
    else $error("Outputs not zero after reset");

  // Checks of the channel handed to the multiplexer.
  // latch on start
  step_pick_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (STEP_ACTIVE_I && !active_q_ff) |=> CHANNEL_O == field_of($past(sel_ff), $past(STEP_I)))
    else $error("Wrong channel for step");

  step_hold_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (STEP_ACTIVE_I && active_q_ff) |=> $stable(CHANNEL_O))
    else $error("Channel moved during a step");

  mid_write_hold_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (STEP_ACTIVE_I && active_q_ff && WR_I) |=> $stable(CHANNEL_O))
    else $error("Channel moved on a mid-step write");

  index_hold_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (STEP_ACTIVE_I && active_q_ff && $changed(STEP_I)) |=> $stable(CHANNEL_O))
    else $error("Channel moved on an index change");

  idle_follow_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (!STEP_ACTIVE_I) |=> CHANNEL_O == field_of($past(sel_ff), $past(STEP_I)))
    else $error("Idle channel not tracking");

  pick_step1_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (STEP_ACTIVE_I && !active_q_ff && STEP_I == 3'h0) |=> CHANNEL_O == $past(step1_channel))
    else $error("Step one channel wrong");

  pick_step2_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (STEP_ACTIVE_I && !active_q_ff && STEP_I == 3'h1) |=> CHANNEL_O == $past(step2_channel))
    else $error("Step two channel wrong");

  pick_step3_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (STEP_ACTIVE_I && !active_q_ff && STEP_I == 3'h2) |=> CHANNEL_O == $past(step3_channel))
    else $error("Step three channel wrong");

  pick_step4_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (STEP_ACTIVE_I && !active_q_ff && STEP_I == 3'h3) |=> CHANNEL_O == $past(step4_channel))
    else $error("Step four channel wrong");

  pick_step5_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (STEP_ACTIVE_I && !active_q_ff && STEP_I == 3'h4) |=> CHANNEL_O == $past(step5_channel))
    else $error("Step five channel wrong");

  pick_step6_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (STEP_ACTIVE_I && !active_q_ff && STEP_I == 3'h5) |=> CHANNEL_O == $past(step6_channel))
    else $error("Step six channel wrong");

  pick_step7_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (STEP_ACTIVE_I && !active_q_ff && STEP_I == 3'h6) |=> CHANNEL_O == $past(step7_channel))
    else $error("Step seven channel wrong");

  pick_step8_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (STEP_ACTIVE_I && !active_q_ff && STEP_I == 3'h7) |=> CHANNEL_O == $past(step8_channel))
    else $error("Step eight channel wrong");

  // Main scenarios worth seeing in a run.
  step_cov_c: cover property (@(posedge CLK_I) STEP_ACTIVE_I && !active_q_ff && STEP_I == 3'h7);
  write_cov_c: cover property (@(posedge CLK_I) WR_I ##[1:2] RD_I);
  midstep_cov_c: cover property (@(posedge CLK_I) STEP_ACTIVE_I && active_q_ff && WR_I);
  idle_cov_c: cover property (@(posedge CLK_I) !STEP_ACTIVE_I && STEP_I == 3'h7);
  unmapped_cov_c: cover property (@(posedge CLK_I) RD_I && !sel_hit(ADDR_I));
endmodule

//--- testbench.sv
// Purpose: Self-checking bench for the input-select register.
// Assumes: Read data stands one cycle after the read strobe.
// Notes: Inputs change by non-blocking assignment on the edge.
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, act = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [2:0] step = 3'h0;
  logic [1:0] chan;
  int error_cnt = 0, compares = 0;
  // Clock at 10 MHz.
  always #50 clk = ~clk;
  assi_select dut (.CLK_I(clk), .RST_B_I(rst_b), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .STEP_I(step), .STEP_ACTIVE_I(act),
    .CHANNEL_O(chan));
  // Compares and counts; four-state so an unknown never matches.
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data is looked at mid-cycle while it stands, then must drop to zero.
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    check("rdata", exp, rdata);
    @(negedge clk);
    check("rdata idle", 32'h0, rdata);
  endtask
  // Step inputs change on an edge; the channel is looked at after the next edge.
  task automatic step_chk(input logic [2:0] s, input logic a, input logic [1:0] exp);
    @(posedge clk);
    step <= s;
    act <= a;
    @(posedge clk);
    @(negedge clk);
    check("channel", {30'h0, exp}, {30'h0, chan});
  endtask
  task automatic give_verdict();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Main sequence of tests.
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    reg_rd(assi_pkg::SEL_OFFSET, 32'h0);
    reg_wr(assi_pkg::SEL_OFFSET, 32'hFFED_CFED);
    reg_rd(assi_pkg::SEL_OFFSET, 32'h3321_0321);
    $display("register test done");
    for (int k = 0; k < 8; k++) begin
      step_chk(3'(k), 1'b0, (k == 7) ? 2'h3 : 2'(k + 1));
    end
    $display("step test done");
    step_chk(3'h2, 1'b1, 2'h3);
    reg_wr(assi_pkg::SEL_OFFSET, 32'h0);
    step_chk(3'h5, 1'b1, 2'h3);
    step_chk(3'h2, 1'b0, 2'h0);
    $display("hold test done");
    reg_wr(8'h44, 32'hFFFF_FFFF);
    reg_rd(8'h44, 32'h0);
    reg_rd(assi_pkg::SEL_OFFSET, 32'h0);
    $display("unmapped test done");
    give_verdict();
  end
  // Whole run needs under 100 cycles; 2000 leaves wide margin.
  initial begin
    repeat (2000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
endmodule
